// *** design/fps_ctrl.sv ***
// block erase sequencer and avalon register front for the boot flash
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic system_power_ok,
  input wire logic ready_busy_out,
  output logic reset_powerdown_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [19:0] flash_addr,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i
);
  fps_cyc_if cyc ();

  fps_pkg::fps_state_e state_q, state_d;
  fps_pkg::fps_result_e result_q;
  logic [31:0] ctrl_q;
  logic [19:0] blk_addr_q;
  logic [7:0] sr_q;
  logic err_q;
  logic retry_q;
  logic req_q;
  logic we_q;
  logic [7:0] wdata_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic pwr_s1_q, pwr_s2_q, pwr_s3_q, pwr_q;
  logic rb_s1_q, rb_s2_q, rb_s3_q, rb_q;

  // avalon: one wait state, then the access completes
  wire bus_req = avs_read || avs_write;
  wire do_wr = avs_write && !wait_q;
  wire ctrl_wr = do_wr && (avs_address == `FPS_REG_CTRL);
  wire addr_wr = do_wr && (avs_address == `FPS_REG_ADDR);
  wire [1:0] op = avs_writedata[1:0];
  wire is_idle = (state_q == fps_pkg::S_IDLE);
  wire start_erase = ctrl_wr && is_idle && (op == 2'(fps_pkg::OP_ERASE));
  wire start_clear = ctrl_wr && is_idle && (op == 2'(fps_pkg::OP_CLEAR));
  wire start_array = ctrl_wr && is_idle && (op == 2'(fps_pkg::OP_ARRAY));
  wire cyc_done = cyc.done;
  wire [7:0] sr_rd = cyc.rdata & `FPS_SR_MASK;
  wire poll_ready = (state_q == fps_pkg::S_POLL) && cyc_done
                    && sr_rd[`FPS_SR_READY];
  wire power_up = pwr_q && ctrl_q[`FPS_CTRL_POWER_EN];

  function automatic fps_pkg::fps_result_e check(input logic [7:0] sr);
    // error bit check (write error counts only with erase error), first match wins
    if (sr[`FPS_SR_SUPPLY_ERR]) begin
      check = fps_pkg::RES_SUPPLY;
    end else if (sr[`FPS_SR_PROTECT_ERR]) begin
      check = fps_pkg::RES_PROTECT;
    end else if (sr[`FPS_SR_ERASE_ERR] && sr[`FPS_SR_WRITE_ERR]) begin
      check = fps_pkg::RES_SEQUENCE;
    end else if (sr[`FPS_SR_ERASE_ERR]) begin
      check = fps_pkg::RES_ERASE;
    end else begin
      check = fps_pkg::RES_OK;
    end
  endfunction : check

  wire fps_pkg::fps_result_e poll_result = check(sr_rd);
  wire [7:0] cmd_byte = (state_d == fps_pkg::S_CLEAR) ? `FPS_CMD_CLEAR_STATUS
    : (state_d == fps_pkg::S_SETUP) ? `FPS_CMD_ERASE_SETUP
    : (state_d == fps_pkg::S_CONFIRM) ? `FPS_CMD_ERASE_CONFIRM
    : `FPS_CMD_READ_ARRAY;
  wire [31:0] status_word = {17'h0_0000, err_q, rb_q, !is_idle,
                             1'b0, 3'(result_q), sr_q};
  wire [31:0] rd_mux = (avs_address == `FPS_REG_CTRL) ? ctrl_q
    : (avs_address == `FPS_REG_ADDR) ? {12'h000, blk_addr_q}
    : (avs_address == `FPS_REG_STATUS) ? status_word : 32'h0000_0000;

  assign cyc.req = req_q;
  assign cyc.we = we_q;
  assign cyc.addr = blk_addr_q;
  assign cyc.wdata = wdata_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fps_pkg::S_IDLE: begin
        if (start_erase && err_q) begin
          state_d = fps_pkg::S_CLEAR;
        end else if (start_erase) begin
          state_d = fps_pkg::S_SETUP;
        end else if (start_clear) begin
          state_d = fps_pkg::S_CLEAR;
        end else if (start_array) begin
          state_d = fps_pkg::S_ARRAY;
        end
      end
      fps_pkg::S_CLEAR: begin
        if (cyc_done) begin
          state_d = retry_q ? fps_pkg::S_SETUP : fps_pkg::S_IDLE;
        end
      end
      fps_pkg::S_SETUP: begin
        if (cyc_done) begin
          state_d = fps_pkg::S_CONFIRM;
        end
      end
      fps_pkg::S_CONFIRM: begin
        if (cyc_done) begin
          state_d = fps_pkg::S_POLL;
        end
      end
      fps_pkg::S_POLL: begin
        // the device answers reads with status until the next command
        if (poll_ready) begin
          state_d = fps_pkg::S_IDLE;
        end
      end
      fps_pkg::S_ARRAY: begin
        if (cyc_done) begin
          state_d = fps_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = fps_pkg::S_IDLE;
      end
    endcase
  end

  // pin inputs: change counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    pwr_s1_q <= system_power_ok;
    pwr_s2_q <= pwr_s1_q;
    pwr_s3_q <= pwr_s2_q;
    rb_s1_q <= ready_busy_out;
    rb_s2_q <= rb_s1_q;
    rb_s3_q <= rb_s2_q;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwr_q <= 1'b0;
      rb_q <= 1'b0;
      reset_powerdown_n <= 1'b0;
    end else begin
      if (pwr_s2_q == pwr_s3_q) begin
        pwr_q <= pwr_s3_q;
      end
      if (rb_s2_q == rb_s3_q) begin
        rb_q <= rb_s3_q;
      end
      reset_powerdown_n <= power_up;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= `FPS_CTRL_RESET;
      blk_addr_q <= 20'h0_0000;
    end else begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q) begin
        rdata_q <= rd_mux;
      end
      if (ctrl_wr) begin
        ctrl_q <= {27'h000_0000, avs_writedata[`FPS_CTRL_POWER_EN], 4'h0};
      end
      if (addr_wr && is_idle) begin
        blk_addr_q <= avs_writedata[19:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= fps_pkg::S_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      retry_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= (state_d != fps_pkg::S_IDLE);
      we_q <= (state_d != fps_pkg::S_POLL);
      wdata_q <= cmd_byte;
      if (is_idle) begin
        retry_q <= start_erase;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sr_q <= 8'h00;
      result_q <= fps_pkg::RES_OK;
      err_q <= 1'b0;
    end else if (state_q == fps_pkg::S_CLEAR && cyc_done) begin
      sr_q <= 8'h00;
      result_q <= fps_pkg::RES_OK;
      err_q <= 1'b0;
    end else if (state_q == fps_pkg::S_POLL && cyc_done) begin
      sr_q <= sr_rd;
      if (poll_ready) begin
        result_q <= poll_result;
        err_q <= (poll_result != fps_pkg::RES_OK);
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  fps_cycle u_cycle (
    .clk_sys(clk_sys),
    .reset(reset),
    .cyc(cyc.eng),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

  AST_CONFIRM_FOLLOWS_SETUP: assert property (@(posedge clk_sys)
    disable iff (reset) state_q == fps_pkg::S_SETUP && cyc_done |=>
    state_q == fps_pkg::S_CONFIRM && wdata_q == `FPS_CMD_ERASE_CONFIRM)
    else $error("confirm did not follow erase setup");
  AST_SERIES_STARTS: assert property (@(posedge clk_sys)
    disable iff (reset) start_erase && !err_q |=>
    state_q == fps_pkg::S_SETUP && wdata_q == `FPS_CMD_ERASE_SETUP)
    else $error("clean erase did not start with setup");
  AST_ARRAY_CMD: assert property (@(posedge clk_sys)
    disable iff (reset) start_array |=> req_q && we_q
    && wdata_q == `FPS_CMD_READ_ARRAY)
    else $error("read array command not issued");
  AST_SUPPLY_FIRST: assert property (@(posedge clk_sys)
    disable iff (reset) poll_ready && sr_rd[`FPS_SR_SUPPLY_ERR] |=>
    result_q == fps_pkg::RES_SUPPLY && err_q)
    else $error("supply error not reported first");
  AST_SEQUENCE_BEFORE_ERASE: assert property (@(posedge clk_sys)
    disable iff (reset) poll_ready && sr_rd[5:3] == 3'h6
    && !sr_rd[`FPS_SR_PROTECT_ERR] |=> result_q == fps_pkg::RES_SEQUENCE)
    else $error("sequence error not recognised");
  AST_CLEAR_BEFORE_RETRY: assert property (@(posedge clk_sys)
    disable iff (reset) start_erase && err_q |=>
    state_q == fps_pkg::S_CLEAR ##1 wdata_q == `FPS_CMD_CLEAR_STATUS)
    else $error("retry without clearing status");
  AST_POWER_DOWN_FOLLOWS: assert property (@(posedge clk_sys)
    disable iff (reset) !pwr_s2_q && !pwr_s3_q |-> ##[1:2] !reset_powerdown_n)
    else $error("reset/power-down not lowered on power loss");
  AST_RESERVED_MASKED: assert property (@(posedge clk_sys)
    disable iff (reset) poll_ready && cyc.rdata[7:1] == 7'h40 |=>
    result_q == fps_pkg::RES_OK && sr_q[0] == 1'b0)
    else $error("reserved status bit leaked into result");

  COV_ERASE_OK: cover property (@(posedge clk_sys) disable iff (reset)
    poll_ready && poll_result == fps_pkg::RES_OK);
  COV_ERASE_PROTECT: cover property (@(posedge clk_sys) disable iff (reset)
    poll_ready && poll_result == fps_pkg::RES_PROTECT);
  COV_RETRY_CLEAR: cover property (@(posedge clk_sys) disable iff (reset)
    state_q == fps_pkg::S_CLEAR && cyc_done && retry_q);
endmodule : fps_ctrl

// *** design/fps_cfg.svh ***
// constants for the flash protect/status/erase controller
// Notes on behaviour
// - Host starts erase with 20H then D0H, both inside the block.
// - Host may run erases back to back and check status per erase.
// - Host writes FFH to return the device to array-read mode.
// - Error check order: supply, protect, sequence, then erase error.
// - Host clears the status register before any retry after an error.
// - Chip select from address decode (the controller drives it low for every cycle, whatever the address); output enable only on reads.
// - Reset/power-down pin follows the system power-good signal (the controller also holds it low while FPS_CTRL_POWER_EN is clear).
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

`define FPS_CMD_ERASE_SETUP 8'h20
`define FPS_CMD_ERASE_CONFIRM 8'hD0
`define FPS_CMD_READ_ARRAY 8'hFF
`define FPS_CMD_CLEAR_STATUS 8'h50

`define FPS_SR_READY 7
`define FPS_SR_ERASE_SUSP 6
`define FPS_SR_ERASE_ERR 5
`define FPS_SR_WRITE_ERR 4
`define FPS_SR_SUPPLY_ERR 3
`define FPS_SR_WRITE_SUSP 2
`define FPS_SR_PROTECT_ERR 1
`define FPS_SR_MASK 8'hFE

`define FPS_REG_CTRL 2'h0
`define FPS_REG_ADDR 2'h1
`define FPS_REG_STATUS 2'h2
`define FPS_CTRL_POWER_EN 4
`define FPS_CTRL_RESET 32'h0000_0010
`define FPS_ADDR_W 20

`define FPS_CLK_NS 4
`define FPS_STROBE_NS 60
`define FPS_ACCESS_NS 90
`define FPS_RECOVER_NS 20
`define FPS_STROBE_CNT ((`FPS_STROBE_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_ACCESS_CNT ((`FPS_ACCESS_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RECOVER_CNT ((`FPS_RECOVER_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_SYNC_LAG 3

`endif

// *** design/fps_pkg.sv ***
// types of the flash protect/status/erase controller
package fps_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_ERASE,
    OP_CLEAR,
    OP_ARRAY
  } fps_op_e;

  typedef enum logic [2:0] {
    RES_OK,
    RES_SUPPLY,
    RES_PROTECT,
    RES_SEQUENCE,
    RES_ERASE
  } fps_result_e;

  typedef enum {
    S_IDLE,
    S_CLEAR,
    S_SETUP,
    S_CONFIRM,
    S_POLL,
    S_ARRAY
  } fps_state_e;

  typedef enum {
    E_IDLE,
    E_SETUP,
    E_STROBE,
    E_HOLD
  } fps_eng_e;
endpackage : fps_pkg

// *** design/fps_cyc_if.sv ***
// one flash bus cycle request between sequencer and cycle engine
`timescale 1ns/1ps
interface fps_cyc_if;
  logic req;
  logic we;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl (output req, output we, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input we, input addr, input wdata,
               output done, output rdata);
endinterface : fps_cyc_if

// *** design/fps_cycle.sv ***
// single read or write cycle on the flash parallel pins
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_cycle (
  input wire logic clk_sys,
  input wire logic reset,
  fps_cyc_if.eng cyc,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [19:0] flash_addr,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i
);
  fps_pkg::fps_eng_e st_q;
  logic [5:0] cnt_q;
  logic [7:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic done_q;
  logic [7:0] rdata_q;

  // write strobe needs only its width; a read also waits out the sync lag
  wire [5:0] strobe_len = cyc.we ? 6'(`FPS_STROBE_CNT)
                                 : 6'(`FPS_ACCESS_CNT + `FPS_SYNC_LAG);
  wire dq_stable = (dq_s2_q == dq_s3_q);
  wire strobe_end = (st_q == fps_pkg::E_STROBE) && (cnt_q == 6'h0)
                    && (cyc.we || dq_stable);

  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;

  always_ff @(posedge clk_sys) begin
    dq_s1_q <= flash_dq_i;
    dq_s2_q <= dq_s1_q;
    dq_s3_q <= dq_s2_q;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= fps_pkg::E_IDLE;
      cnt_q <= 6'h0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= 20'h0_0000;
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cnt_q != 6'h0) begin
        cnt_q <= cnt_q - 6'h1;
      end
      case (st_q)
        fps_pkg::E_IDLE: begin
          if (cyc.req && !done_q) begin
            flash_ce_n <= 1'b0;
            flash_addr <= cyc.addr;
            flash_dq_o <= cyc.wdata;
            flash_dq_oe <= cyc.we;
            st_q <= fps_pkg::E_SETUP;
          end
        end
        fps_pkg::E_SETUP: begin
          flash_we_n <= !cyc.we;
          flash_oe_n <= cyc.we;
          cnt_q <= strobe_len;
          st_q <= fps_pkg::E_STROBE;
        end
        fps_pkg::E_STROBE: begin
          if (strobe_end) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            rdata_q <= dq_s3_q;
            cnt_q <= 6'(`FPS_RECOVER_CNT);
            st_q <= fps_pkg::E_HOLD;
          end
        end
        fps_pkg::E_HOLD: begin
          if (cnt_q == 6'h0) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done_q <= 1'b1;
            st_q <= fps_pkg::E_IDLE;
          end
        end
        default: begin
          st_q <= fps_pkg::E_IDLE;
        end
      endcase
    end
  end

  AST_NO_READ_WRITE_CLASH: assert property (@(posedge clk_sys)
    disable iff (reset) !(!flash_oe_n && !flash_we_n))
    else $error("output enable and write enable low together");
  AST_OE_ONLY_SELECTED: assert property (@(posedge clk_sys)
    disable iff (reset) !flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
    else $error("output enable asserted without chip select");
  AST_DATA_HELD_OVER_WE: assert property (@(posedge clk_sys)
    disable iff (reset) $rose(flash_we_n) |-> flash_dq_oe ##1 !flash_ce_n)
    else $error("write data released with the strobe");
endmodule : fps_cycle

// *** testbench/fps_flash_model.sv ***
// behavioural boot-block flash: commands, protection, status
`timescale 1ns/1ps
module fps_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [19:0] addr,
  input wire logic [7:0] din,
  input wire logic rp_n,
  input wire logic rp_hv,
  input wire logic wp_n,
  input wire logic supply_ok,
  input wire logic [1:0] fault,
  input wire logic [15:0] busy_ns,
  output logic [7:0] dout,
  output logic dout_oe,
  output logic ry_low
);
  logic [7:0] sr_q = 8'h80;
  logic setup_q = 1'b0;
  logic array_q = 1'b1;
  wire boot = addr[19:16] == 4'hF;
  // fault injection is only ever commanded by the bench
  // fault 3 ends the erase suspended: ready and erase-suspended both set
  wire [7:0] fx = (fault == 2'h1) ? 8'h30 : (fault == 2'h2) ? 8'h20
    : (fault == 2'h3) ? 8'h40 : 8'h00;
  wire locked = !rp_n || (!rp_hv && !wp_n && boot);
  initial ry_low = 1'b0;
  assign dout_oe = !ce_n && !oe_n && rp_n;
  // bit 0 is undefined, so drive it high to catch a missing mask
  assign dout = array_q ? addr[7:0] : {sr_q[7:1], 1'b1};
  always @(posedge we_n) begin
    if (!ce_n && rp_n) begin
      array_q <= (din == 8'hFF);
      setup_q <= (din == 8'h20);
      if (din == 8'h50)
        sr_q <= sr_q & 8'hC5;
      if (din == 8'hD0 && !setup_q)
        sr_q <= sr_q | 8'h30;
      if (din == 8'hD0 && setup_q) begin
        // supply, wp_n and rp_hv are looked at only here
        if (!supply_ok)
          sr_q <= sr_q | 8'h28;
        else if (locked)
          sr_q <= sr_q | 8'h22 | fx;
        else begin
          sr_q[7:6] <= 2'h0;
          ry_low <= 1'b1;
          #(busy_ns);
          sr_q <= {1'b1, sr_q[6:0]} | fx;
          ry_low <= 1'b0;
        end
      end
    end
  end
endmodule : fps_flash_model

// *** testbench/fps_ctrl_tb.sv ***
// self-checking bench for the boot flash erase controller
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_ctrl_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic system_power_ok = 1'b1;
  logic rp_n, ce_n, oe_n, we_n, c_oe, m_oe, ry_low;
  logic [19:0] f_addr;
  logic [7:0] c_dq, m_dq;
  logic [7:0] dq_last = 8'h00;
  logic rp_hv = 1'b0;
  logic wp_n = 1'b1;
  logic supply_ok = 1'b1;
  logic [1:0] fault = 2'h0;
  logic [15:0] busy_ns = 16'h0190;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // a released bus shows the inverse of its last value
  wire [7:0] dq = m_oe ? m_dq : (c_oe ? c_dq : ~dq_last);
  wire ryby = !ry_low;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (m_oe || c_oe)
      dq_last <= dq;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      end_sim();
    end
  end

  fps_ctrl u_dut (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .system_power_ok(system_power_ok), .ready_busy_out(ryby),
    .reset_powerdown_n(rp_n), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_o(c_dq),
    .flash_dq_oe(c_oe), .flash_dq_i(dq));
  fps_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(f_addr), .din(dq), .rp_n(rp_n), .rp_hv(rp_hv), .wp_n(wp_n),
    .supply_ok(supply_ok), .fault(fault), .busy_ns(busy_ns),
    .dout(m_dq), .dout_oe(m_oe), .ry_low(ry_low));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task av_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask : av_wr

  task av_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd

  task run_op(input logic [1:0] op, input logic [19:0] a,
              output logic [31:0] st);
    av_wr(`FPS_REG_ADDR, {12'h000, a});
    av_wr(`FPS_REG_CTRL, {27'h0, 1'b1, 2'h0, op});
    st = 32'h0000_1000;
    while (st[12] !== 1'b0)
      av_rd(`FPS_REG_STATUS, st);
  endtask : run_op

  task erase(input logic [19:0] a, input logic [7:0] sr,
             input logic [2:0] res);
    logic [31:0] st;
    run_op(fps_pkg::OP_ERASE, a, st);
    // pin released, not busy, error flag set for any failing result
    chk({17'h0, st[14:0]}, {17'h0, res != 3'h0, 3'h4, res, sr});
  endtask : erase

  task t_regs();
    logic [31:0] d;
    av_rd(`FPS_REG_CTRL, d);
    chk(d, `FPS_CTRL_RESET);
    av_wr(`FPS_REG_ADDR, 32'hFFFF_FFFF);
    av_rd(`FPS_REG_ADDR, d);
    chk(d, 32'h000F_FFFF);
    av_rd(2'h3, d);
    chk(d, 32'h0);
  endtask : t_regs

  task t_power();
    repeat (10) @(posedge clk_sys);
    chk({31'h0, rp_n}, 32'h1);
    system_power_ok <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({31'h0, rp_n}, 32'h0);
    system_power_ok <= 1'b1;
    av_wr(`FPS_REG_CTRL, 32'h0);
    repeat (10) @(posedge clk_sys);
    chk({31'h0, rp_n}, 32'h0);
    av_wr(`FPS_REG_CTRL, `FPS_CTRL_RESET);
    repeat (10) @(posedge clk_sys);
    chk({31'h0, rp_n}, 32'h1);
  endtask : t_power

  task t_lock();
    erase(20'h1_0000, 8'h80, fps_pkg::RES_OK);
    wp_n <= 1'b0;
    erase(20'hF_0000, 8'hA2, fps_pkg::RES_PROTECT);
    erase(20'h1_0000, 8'h80, fps_pkg::RES_OK);
    rp_hv <= 1'b1;
    erase(20'hF_0000, 8'h80, fps_pkg::RES_OK);
    rp_hv <= 1'b0;
    wp_n <= 1'b1;
    erase(20'hF_0000, 8'h80, fps_pkg::RES_OK);
  endtask : t_lock

  task t_supply();
    logic [31:0] st;
    supply_ok <= 1'b0;
    wp_n <= 1'b0;
    erase(20'hF_0000, 8'hA8, fps_pkg::RES_SUPPLY);
    supply_ok <= 1'b1;
    wp_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({24'h0, u_flash.sr_q}, 32'hA8);
    run_op(fps_pkg::OP_CLEAR, 20'h0_0000, st);
    chk({24'h0, u_flash.sr_q}, 32'h80);
  endtask : t_supply

  task t_fault();
    fault <= 2'h1;
    erase(20'h2_0000, 8'hB0, fps_pkg::RES_SEQUENCE);
    wp_n <= 1'b0;
    erase(20'hF_0000, 8'hB2, fps_pkg::RES_PROTECT);
    wp_n <= 1'b1;
    fault <= 2'h2;
    erase(20'h2_0000, 8'hA0, fps_pkg::RES_ERASE);
    fault <= 2'h3;
    erase(20'h2_0000, 8'hC0, fps_pkg::RES_OK);
    fault <= 2'h0;
  endtask : t_fault

  task t_busy();
    logic [31:0] st;
    busy_ns <= 16'h0FA0;
    av_wr(`FPS_REG_ADDR, 32'h0002_0000);
    av_wr(`FPS_REG_CTRL, 32'h0000_0011);
    repeat (200) @(posedge clk_sys);
    av_rd(`FPS_REG_STATUS, st);
    chk({30'h0, st[13:12]}, 32'h1);
    av_wr(`FPS_REG_ADDR, 32'h0003_0000);
    av_rd(`FPS_REG_ADDR, st);
    chk(st, 32'h0002_0000);
    st = 32'h0000_1000;
    while (st[12] !== 1'b0)
      av_rd(`FPS_REG_STATUS, st);
    chk({24'h0, st[7:0]}, 32'h80);
    busy_ns <= 16'h0190;
    run_op(fps_pkg::OP_ARRAY, 20'h0_0000, st);
    chk({31'h0, u_flash.array_q}, 32'h1);
  endtask : t_busy

  task end_sim();
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_power();
    t_lock();
    t_supply();
    t_fault();
    t_busy();
    end_sim();
  end
endmodule : fps_ctrl_tb
